// file: mcr_regs.svh
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH
// register addresses on the serial port
`define MCR_ADDR_CTRL 6'h01
`define MCR_ADDR_GAIN 6'h02
`define MCR_ADDR_MUX 6'h03
`define MCR_ADDR_OTHR 6'h04
`define MCR_ADDR_IEN 6'h05
`define MCR_ADDR_ISTAT 6'h17
// reset values
`define MCR_RST_CTRL 8'h00
`define MCR_RST_GAIN 8'h00
`define MCR_RST_MUX 8'h00
`define MCR_RST_OTHR 8'hFF
`define MCR_RST_IEN 8'h00
// writable bit masks, undefined bits read zero
`define MCR_MASK_CTRL 8'h7F
`define MCR_MASK_GAIN 8'hDF
`define MCR_MASK_MUX 8'h17
`define MCR_MASK_IEN 8'h07
// field positions
`define MCR_BIT_ARM 4
`define MCR_BIT_OT 0
`define MCR_BIT_UV 1
`define MCR_BIT_OC 2
// serial frame: rw bit, 6 address bits, a spare bit, then 8 data bits
`define MCR_FRAME_BITS 5'd16
`endif

// file: mcr_pkg.sv
package mcr_pkg;
	// decoded control outputs
	typedef struct packed {
		logic chip_on;
		logic temp_sensor_on;
		logic curr_amp_on;
		logic volt_amp_on;
		logic adc_ref_on;
		logic overcur_on;
		logic overcur_secondary;
	} mcr_power_t;
	// converter input choices
	typedef enum logic [2:0] {
		MCR_IN_CURR_AMP, MCR_IN_VOLT_AMP, MCR_IN_SECONDARY, MCR_IN_SUPPLY,
		MCR_IN_MAIN, MCR_IN_AUX1, MCR_IN_RSVD6, MCR_IN_RSVD7
	} mcr_input_t;
	// shift engine state
	typedef enum logic [1:0] {MCR_IDLE, MCR_SHIFT, MCR_DONE} mcr_state_t;
endpackage

// file: mcr_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for pin inputs
module mcr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= INIT;
			q_o <= INIT;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // mcr_sync

// file: mcr_top.sv
`timescale 1ns/1ps
`include "mcr_regs.svh"
module mcr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic serial_select_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic [7:0] temp_value_i,
	input wire logic under_voltage_i,
	input wire logic over_current_i,
	output mcr_pkg::mcr_power_t power_o,
	output logic [4:0] curr_gain_code_o,
	output logic [6:0] curr_gain_o, // wide enough for the top code, 64
	output logic [1:0] volt_gain_code_o,
	output logic [3:0] volt_gain_o, // wide enough for the top code, 8
	output mcr_pkg::mcr_input_t input_sel_o,
	output logic conv_start_o,
	output logic conv_armed_o,
	output logic over_temp_o,
	output logic warning_o,
	output logic irq_flag_o,
	output logic irq_out_n_o
);
	// synchronised pins: sclk, select, mosi
	logic [2:0] pin_s;
	mcr_sync #(.W(3), .INIT(3'b010)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({sclk_i, serial_select_n_i, mosi_i}),
		.q_o(pin_s)
	);
	logic sclk_s, sel_n_s, mosi_s;
	assign sclk_s = pin_s[2];
	assign sel_n_s = pin_s[1];
	assign mosi_s = pin_s[0];

	// edge detection on the synchronised copies
	logic sclk_d_q, sel_n_d_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_d_q <= 1'b0;
			sel_n_d_q <= 1'b1;
		end else begin
			sclk_d_q <= sclk_s;
			sel_n_d_q <= sel_n_s;
		end
	end
	logic sclk_rise, sclk_fall, sel_fall, sel_rise;
	assign sclk_rise = sclk_s & ~sclk_d_q;
	assign sclk_fall = ~sclk_s & sclk_d_q;
	assign sel_fall = ~sel_n_s & sel_n_d_q;
	assign sel_rise = sel_n_s & ~sel_n_d_q;

	// registers
	logic [7:0] ctrl_q, gain_q, mux_q, othr_q, ien_q;
	logic [2:0] istat_q; // sticky event bits, upper status bits read zero

	// serial frame engine: bit15 = 1 read, bits 14:9 address, 7:0 data
	mcr_pkg::mcr_state_t st_q;
	logic [4:0] bit_cnt_q; // bits taken so far
	logic [15:0] sh_q; // incoming shift register
	logic [7:0] tx_q; // outgoing read data
	logic wr_stb, rd_stb; // one-cycle access pulses
	logic [5:0] acc_addr;
	assign acc_addr = sh_q[14:9];
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= mcr_pkg::MCR_IDLE;
			bit_cnt_q <= 5'h00;
			sh_q <= 16'h0000;
		end else begin
			case (st_q)
				mcr_pkg::MCR_IDLE: begin
					// frame opens on select falling edge
					if (sel_fall) begin
						st_q <= mcr_pkg::MCR_SHIFT;
						bit_cnt_q <= 5'h00;
					end
				end
				mcr_pkg::MCR_SHIFT: begin
					if (sel_rise) begin
						// short frame aborted, nothing written
						st_q <= mcr_pkg::MCR_IDLE;
					end else if (sclk_rise) begin
						sh_q <= {sh_q[14:0], mosi_s};
						bit_cnt_q <= bit_cnt_q + 5'h01;
						if (bit_cnt_q == `MCR_FRAME_BITS - 5'd1) begin
							st_q <= mcr_pkg::MCR_DONE;
						end
					end
				end
				mcr_pkg::MCR_DONE: begin
					// wait for select release before next frame
					if (sel_rise) begin
						st_q <= mcr_pkg::MCR_IDLE;
					end
				end
				default: st_q <= mcr_pkg::MCR_IDLE;
			endcase
		end
	end
	// write taken at select release after the full frame, read when the last address bit is in
	assign wr_stb = (st_q == mcr_pkg::MCR_DONE) && sel_rise && !sh_q[15];
	assign rd_stb = (st_q == mcr_pkg::MCR_SHIFT) && sclk_rise
		&& (bit_cnt_q == 5'd6) && sh_q[5];
	logic [5:0] rd_addr;
	assign rd_addr = {sh_q[4:0], mosi_s};

	// read mux; undefined bits already zero in storage
	logic [7:0] rd_data;
	always_comb begin
		case (rd_addr)
			`MCR_ADDR_CTRL: rd_data = ctrl_q;
			`MCR_ADDR_GAIN: rd_data = gain_q;
			`MCR_ADDR_MUX: rd_data = mux_q;
			`MCR_ADDR_OTHR: rd_data = othr_q;
			`MCR_ADDR_IEN: rd_data = ien_q;
			`MCR_ADDR_ISTAT: rd_data = {5'h00, istat_q};
			default: rd_data = 8'h00;
		endcase
	end

	// read shifter, msb first on sclk falling edges
	logic rd_act_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_q <= 8'h00;
			rd_act_q <= 1'b0;
		end else if (rd_stb) begin
			tx_q <= rd_data;
			rd_act_q <= 1'b1;
		end else if (sel_rise || st_q == mcr_pkg::MCR_IDLE) begin
			rd_act_q <= 1'b0;
		end else if (rd_act_q && sclk_fall && bit_cnt_q > 5'd8) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end
	// output registered; drives only during a read, from the last address bit until select release
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end else begin
			miso_o <= tx_q[7];
			miso_oe_o <= rd_act_q && !sel_n_s;
		end
	end

	// configuration registers; masks keep undefined bits zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= `MCR_RST_CTRL;
			gain_q <= `MCR_RST_GAIN;
			othr_q <= `MCR_RST_OTHR;
			ien_q <= `MCR_RST_IEN;
		end else if (wr_stb) begin
			case (acc_addr)
				`MCR_ADDR_CTRL: ctrl_q <= sh_q[7:0] & `MCR_MASK_CTRL;
				`MCR_ADDR_GAIN: gain_q <= sh_q[7:0] & `MCR_MASK_GAIN;
				`MCR_ADDR_OTHR: othr_q <= sh_q[7:0];
				`MCR_ADDR_IEN: ien_q <= sh_q[7:0] & `MCR_MASK_IEN;
				default: ;
			endcase
		end
	end

	// multiplexer register; arm bit self-clears on the next select falling edge
	logic conv_go;
	assign conv_go = mux_q[`MCR_BIT_ARM] && sel_fall;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mux_q <= `MCR_RST_MUX;
		end else if (wr_stb && acc_addr == `MCR_ADDR_MUX) begin
			mux_q <= sh_q[7:0] & `MCR_MASK_MUX;
		end else if (conv_go) begin
			mux_q[`MCR_BIT_ARM] <= 1'b0;
		end
	end

	// event detection; temperature compared only while the sensor is on
	logic ot_now;
	assign ot_now = ctrl_q[1] && (temp_value_i > othr_q);
	logic uv_s, oc_s; // pin events synchronised
	logic [1:0] ev_pins;
	mcr_sync #(.W(2), .INIT(2'b00)) u_sync_ev (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({under_voltage_i, over_current_i}),
		.q_o(ev_pins)
	);
	assign uv_s = ev_pins[1];
	assign oc_s = ev_pins[0] && ctrl_q[5];
	logic [2:0] ev_now;
	assign ev_now = {oc_s, uv_s, ot_now};

	// sticky status per source; a set in the read cycle wins over the clear
	logic ist_rd;
	assign ist_rd = rd_stb && rd_addr == `MCR_ADDR_ISTAT;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stat
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					istat_q[gi] <= 1'b0;
				end else if (ev_now[gi]) begin
					istat_q[gi] <= 1'b1;
				end else if (ist_rd) begin
					istat_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// decoded outputs, all registered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			power_o <= '0;
			curr_gain_code_o <= 5'h00;
			curr_gain_o <= 7'h02;
			volt_gain_code_o <= 2'h0;
			volt_gain_o <= 4'h2;
			input_sel_o <= mcr_pkg::MCR_IN_CURR_AMP;
			conv_start_o <= 1'b0;
			conv_armed_o <= 1'b0;
			over_temp_o <= 1'b0;
			warning_o <= 1'b0;
			irq_flag_o <= 1'b0;
			irq_out_n_o <= 1'b1;
		end else begin
			power_o.chip_on <= ctrl_q[0];
			power_o.temp_sensor_on <= ctrl_q[1];
			power_o.curr_amp_on <= ctrl_q[2];
			power_o.volt_amp_on <= ctrl_q[3];
			power_o.adc_ref_on <= ctrl_q[4];
			power_o.overcur_on <= ctrl_q[5];
			power_o.overcur_secondary <= ctrl_q[6];
			curr_gain_code_o <= gain_q[4:0];
			curr_gain_o <= {1'b0, gain_q[4:0], 1'b0} + 7'h02;
			volt_gain_code_o <= gain_q[7:6];
			volt_gain_o <= {1'b0, gain_q[7:6], 1'b0} + 4'h2;
			input_sel_o <= mcr_pkg::mcr_input_t'(mux_q[2:0]);
			// conversion needs the reference on to be meaningful
			conv_start_o <= conv_go && ctrl_q[4];
			conv_armed_o <= mux_q[`MCR_BIT_ARM];
			over_temp_o <= ot_now;
			warning_o <= |istat_q[2:0];
			irq_flag_o <= |(istat_q[2:0] & ien_q[2:0]);
			irq_out_n_o <= ~|(istat_q[2:0] & ien_q[2:0]);
		end
	end
endmodule // mcr_top

// file: mcr_sva.sv
`timescale 1ns/1ps
// watches the register bank outputs at the top ports
module mcr_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic serial_select_n_i,
	input wire logic [7:0] temp_value_i,
	input wire logic miso_oe_o,
	input wire mcr_pkg::mcr_power_t power_o,
	input wire logic [4:0] curr_gain_code_o,
	input wire logic [6:0] curr_gain_o,
	input wire logic [1:0] volt_gain_code_o,
	input wire logic [3:0] volt_gain_o,
	input wire logic conv_start_o,
	input wire logic conv_armed_o,
	input wire logic over_temp_o,
	input wire logic warning_o,
	input wire logic irq_flag_o,
	input wire logic irq_out_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// select idle long enough for the synchroniser to settle
	sequence s_sel_idle;
		serial_select_n_i [*8];
	endsequence
	// a zero temperature can exceed no threshold
	sequence s_cold;
		(temp_value_i == 8'h00) [*3];
	endsequence
	a_chip_off: assert property ($fell(rst_i) |-> power_o == '0)
		else $error("power enables not clear after reset");
	// applied gain follows its code in every cycle, top codes included
	a_curr_gain: assert property (curr_gain_o == {1'b0, curr_gain_code_o, 1'b0} + 7'h02)
		else $error("current gain wrong");
	a_volt_gain: assert property (volt_gain_o == {1'b0, volt_gain_code_o, 1'b0} + 4'h2)
		else $error("voltage gain wrong");
	a_start_ref: assert property (conv_start_o |-> power_o.adc_ref_on)
		else $error("conversion without reference");
	a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than a pulse");
	a_arm_clear: assert property (conv_start_o |-> ##[0:2] !conv_armed_o)
		else $error("arm not cleared by start");
	a_cold_temp: assert property (s_cold |-> !over_temp_o)
		else $error("over temperature below threshold");
	a_warn_irq: assert property (irq_flag_o |-> warning_o)
		else $error("interrupt without warning");
	a_irq_pin: assert property (irq_out_n_o == !irq_flag_o)
		else $error("interrupt pin disagrees with flag");
	a_oe_idle: assert property (s_sel_idle |-> !miso_oe_o)
		else $error("data out driven while deselected");
endmodule // mcr_sva

bind mcr_top mcr_sva u_sva (.clk_i, .rst_i, .serial_select_n_i, .temp_value_i, .miso_oe_o,
	.power_o, .curr_gain_code_o, .curr_gain_o, .volt_gain_code_o, .volt_gain_o, .conv_start_o,
	.conv_armed_o, .over_temp_o, .warning_o, .irq_flag_o, .irq_out_n_o);

// file: mcr_host.sv
`timescale 1ns/1ps
// host end of the serial port; link clock idles low between frames
module mcr_host (
	output logic sclk_o,
	output logic ssn_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic last = 1'b0; // last driven data-out level
	logic line; // level the host sees
	// a released line must not keep its old bit
	assign line = miso_oe_i ? miso_i : ~last;
	always @(miso_i, miso_oe_i) if (miso_oe_i) last = miso_i;
	initial begin
		sclk_o = 1'b0;
		ssn_o = 1'b1;
		mosi_o = 1'b0;
	end
	// n bits of rw, address, spare, data, msb first
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
		input int n, output logic [7:0] q);
		logic [15:0] f;
		f = {rd, a, 1'b0, d};
		q = 8'h00;
		ssn_o = 1'b0; // this fall starts an armed conversion
		#100;
		for (int i = 15; i >= 16 - n; i--) begin
			mosi_o = f[i];
			#100 sclk_o = 1'b1;
			#99 q = {q[6:0], line}; // sample late: data out lags the fall
			#1 sclk_o = 1'b0;
		end
		#100 ssn_o = 1'b1;
		mosi_o = ~mosi_o; // idle line carries no frame bit
		#100;
	endtask
endmodule // mcr_host

// file: mcr_top_tb.sv
`timescale 1ns/1ps
module mcr_top_tb;
	logic clk_i = 0, rst_i = 1, uv = 0, oc = 0; // clock, reset, event pins
	logic sclk, ssn, mosi, miso, oe, cs, armed, ot, warn, irqf, irqn;
	logic [7:0] temp = 8'h00, q; // temperature pin, read data
	logic [6:0] pr; // power enables in register order
	logic [4:0] cg; // current gain code
	logic [6:0] cgv; // applied current gain
	logic [1:0] vg; // voltage gain code
	logic [3:0] vgv; // applied voltage gain
	mcr_pkg::mcr_power_t pwr;
	mcr_pkg::mcr_input_t sel;
	int m[6] = '{0, 0, 0, 0, 'hFF, 0}; // register model
	int k[6] = '{0, 'h7F, 'hDF, 'h17, 'hFF, 'h07}; // writable bits
	int err_total = 0, compares = 0, cyc = 0, nst = 0, a;
	assign pr = {<<{pwr}};
	mcr_host h (.sclk_o(sclk), .ssn_o(ssn), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(oe));
	mcr_top dut (.clk_i, .rst_i, .sclk_i(sclk), .serial_select_n_i(ssn), .mosi_i(mosi),
		.miso_o(miso), .miso_oe_o(oe), .temp_value_i(temp), .under_voltage_i(uv),
		.over_current_i(oc), .power_o(pwr), .curr_gain_code_o(cg), .curr_gain_o(cgv),
		.volt_gain_code_o(vg), .volt_gain_o(vgv), .input_sel_o(sel), .conv_start_o(cs),
		.conv_armed_o(armed), .over_temp_o(ot), .warning_o(warn), .irq_flag_o(irqf),
		.irq_out_n_o(irqn));
	always #12.5 clk_i = ~clk_i;
	// start pulses counted; hang guard
	always @(posedge clk_i) begin
		nst += cs;
		if (++cyc == 40000) begin
			err_total++;
			end_sim;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task wr(input int ad, input int d);
		m[3] &= 'hEF; // every frame start disarms
		h.xfer(1'b0, ad[5:0], d[7:0], 16, q);
		m[ad] = d & k[ad];
		tick(4);
	endtask
	task rd(input int ad);
		m[3] &= 'hEF; // every frame start disarms
		h.xfer(1'b1, ad[5:0], 8'h00, 16, q);
		tick(4);
	endtask
	task end_sim;
		if (err_total == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(82164));
		tick(20);
		rst_i = 1'b0;
		tick(4);
		for (a = 0; a < 6; a++) begin
			rd(a);
			chk(q, m[a]);
		end
		for (int i = 0; i < 25; i++) begin
			a = 1 + $urandom % 5;
			wr(a, $urandom);
			rd(a);
			chk(q, m[a]);
			chk({1'b0, pr}, m[1]);
			chk({vg, 1'b0, cg}, m[2]);
			chk(cgv, 2 * (m[2] & 'h1F) + 2);
			chk(vgv, 2 * (m[2] >> 6) + 2);
		end
		for (int i = 0; i < 8; i++) begin
			wr(3, i);
			chk({5'h00, sel}, i);
		end
		h.xfer(1'b0, 6'h01, 8'h55, 8, q); // short frame writes nothing
		rd(1);
		chk(q, m[1]);
		wr(1, 'h22);
		wr(4, 'h10);
		wr(5, 0);
		temp = 8'h11;
		tick(4);
		chk({6'h00, ot, irqf}, 8'h02);
		temp = 8'h00;
		wr(5, 1);
		chk({5'h00, warn, irqf, irqn}, 8'h06);
		rd('h17);
		chk(q, 8'h01);
		for (int j = 1; j < 3; j++) begin
			wr(5, 0);
			if (j == 1) uv = 1'b1;
			else oc = 1'b1;
			tick(6);
			uv = 1'b0;
			oc = 1'b0;
			tick(4);
			chk({6'h00, warn, irqf}, 8'h02);
			wr(5, 1 << j);
			chk({7'h00, irqf}, 8'h01);
			rd('h17);
			chk(q, 1 << j);
		end
		wr(1, 'h10); // reference on before arming
		wr(3, 'h10);
		chk({7'h00, armed}, 8'h01);
		a = nst;
		rd(1);
		chk(nst - a, 1);
		end_sim;
	end
endmodule // mcr_top_tb
